// *** design/iom_pkg.sv ***
package iom_pkg;
    localparam int OPCODE_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int DEST_BIT = 7;
    localparam int OPSEL_HI = 13;
    localparam int OPSEL_LO = 8;
    localparam int LIT_SEL_LO = 8;
    localparam logic [5:0] INCREMENT_FILE_OP = 6'h0a;
    localparam logic [5:0] OR_WORK_WITH_FILE_OP = 6'h04;
    localparam logic [5:0] MOVE_FILE_OP = 6'h08;
    localparam logic [5:0] OR_LITERAL_INTO_WORK_OP = 6'h38;
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_INC = 3'b001,
        OP_ORL = 3'b010,
        OP_ORF = 3'b011,
        OP_MOV = 3'b100
    } iom_op_type;

    typedef struct packed {
        iom_op_type op;
        logic to_file;
        logic [6:0] addr;
        logic [7:0] literal;
    } iom_dec_type;

    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } iom_file_wr_type;
endpackage

// *** design/iom_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module iom_decoder (
    input wire logic [13:0] opcode_in,
    output iom_pkg::iom_dec_type dec_out
);
    import iom_pkg::*;

    logic [5:0] sel;

    always_comb begin
        sel = opcode_in[OPSEL_HI:OPSEL_LO];
        dec_out.to_file = opcode_in[DEST_BIT];
        dec_out.addr = opcode_in[ADDR_W-1:0];
        dec_out.literal = opcode_in[DATA_W-1:0];
        if (sel == INCREMENT_FILE_OP) begin
            dec_out.op = OP_INC;
        end else if (sel == OR_WORK_WITH_FILE_OP) begin
            dec_out.op = OP_ORF;
        end else if (sel == MOVE_FILE_OP) begin
            dec_out.op = OP_MOV;
        end else if (sel == OR_LITERAL_INTO_WORK_OP) begin
            dec_out.op = OP_ORL;
        end else begin
            dec_out.op = OP_NONE;
        end
        if (sel == OR_LITERAL_INTO_WORK_OP) begin
            dec_out.to_file = 1'b0;
        end
    end
endmodule // iom_decoder
`default_nettype wire

// *** design/iom_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// - increment-file adds one to the file register; zero flag from 8-bit result.
// - destination bit 0 writes working register, 1 writes file register back.
// - or-literal ORs working register with immediate into working register, zero flag updated.
// - or-work-with-file ORs working and file register, routed by destination, zero flag.
// - move-file copies file register to working register or back to itself.
// - move-file updates zero flag from moved value for both destinations.
module iom_exec #(
    parameter int DATA_WIDTH = iom_pkg::DATA_W,
    parameter int ADDR_WIDTH = iom_pkg::ADDR_W,
    parameter int OPCODE_WIDTH = iom_pkg::OPCODE_W
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic valid_in,
    input wire logic [13:0] opcode_in,
    input wire logic [7:0] file_data_in,
    output logic [6:0] file_addr_out,
    output iom_pkg::iom_file_wr_type file_wr_out,
    output logic [7:0] work_out,
    output logic zero_out,
    output logic handled_out
);
    import iom_pkg::*;

    // the carrier structs and the decoder are cut for the documented widths only
    if (DATA_WIDTH != DATA_W) begin : g_bad_data_width
        $error("iom_exec: DATA_WIDTH must equal the package data width");
    end
    if (ADDR_WIDTH != ADDR_W) begin : g_bad_addr_width
        $error("iom_exec: ADDR_WIDTH must equal the package address width");
    end
    if (OPCODE_WIDTH != OPCODE_W) begin : g_bad_opcode_width
        $error("iom_exec: OPCODE_WIDTH must equal the package opcode width");
    end
    // the destination bit must sit above the address field
    if (DEST_BIT < ADDR_WIDTH) begin : g_bad_dest_bit
        $error("iom_exec: destination bit overlaps the file address");
    end

    iom_dec_type dec;
    logic [DATA_WIDTH-1:0] work_q;
    logic [DATA_WIDTH-1:0] work_d;
    logic zero_q;
    logic zero_d;
    iom_file_wr_type wr_q;
    iom_file_wr_type wr_d;
    logic [DATA_WIDTH-1:0] result;
    logic hit;
    logic is_inc;
    logic is_orl;
    logic is_orf;
    logic is_mov;
    logic [DATA_WIDTH-1:0] or_operand;
    logic [DATA_WIDTH-1:0] or_result;
    logic [DATA_WIDTH-1:0] inc_result;
    logic [DATA_WIDTH-1:0] inc_carry;
    logic result_zero;
    logic writes_file;
    logic writes_work;

    iom_decoder u_decoder (
        .opcode_in(opcode_in),
        .dec_out(dec)
    );

    // file read is combinational so the whole op retires in one cycle
    assign file_addr_out = dec.addr;
    assign hit = valid_in && (dec.op != OP_NONE);
    assign handled_out = hit;

    // one flag per op keeps the result mux and the routing readable
    always_comb begin
        is_inc = 1'b0;
        is_orl = 1'b0;
        is_orf = 1'b0;
        is_mov = 1'b0;
        case (dec.op)
            OP_INC: begin
                is_inc = 1'b1;
            end
            OP_ORL: begin
                is_orl = 1'b1;
            end
            OP_ORF: begin
                is_orf = 1'b1;
            end
            OP_MOV: begin
                is_mov = 1'b1;
            end
            default: begin
                is_inc = 1'b0;
            end
        endcase
    end

    // the or shares one gate row: literal for the immediate form, file data otherwise
    always_comb begin
        if (is_orl) begin
            or_operand = dec.literal;
        end else begin
            or_operand = file_data_in;
        end
    end

    // per-bit datapath; a ripple incrementer is cheap enough at eight bits
    assign inc_carry[0] = 1'b1;
    for (genvar i = 0; i < DATA_WIDTH; i++) begin : g_bit
        assign or_result[i] = work_q[i] | or_operand[i];
        assign inc_result[i] = file_data_in[i] ^ inc_carry[i];
        if (i < DATA_WIDTH - 1) begin : g_carry
            // carry out of the top bit is dropped, so ff wraps to 00
            assign inc_carry[i+1] = file_data_in[i] & inc_carry[i];
        end
    end

    // result mux; an unknown op leaves the working register as it is
    always_comb begin
        result = work_q;
        if (is_inc) begin
            result = inc_result;
        end else if (is_orl || is_orf) begin
            result = or_result;
        end else if (is_mov) begin
            result = file_data_in;
        end
    end

    assign result_zero = (result == '0);

    // the immediate form has no destination bit and always lands in the working register
    always_comb begin
        writes_file = 1'b0;
        writes_work = 1'b0;
        if (hit) begin
            if (dec.to_file && !is_orl) begin
                writes_file = 1'b1;
            end else begin
                writes_work = 1'b1;
            end
        end
    end

    // working register group
    always_comb begin
        work_d = work_q;
        if (writes_work) begin
            work_d = result;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            work_q <= WORK_RESET;
        end else begin
            work_q <= work_d;
        end
    end

    // zero flag group; move updates it for either destination, so moving onto itself tests
    always_comb begin
        zero_d = zero_q;
        if (hit) begin
            zero_d = result_zero;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            zero_q <= ZERO_RESET;
        end else begin
            zero_q <= zero_d;
        end
    end

    // file write group; the register file must apply the pulse, bypass is its job
    always_comb begin
        wr_d = '0;
        wr_d.addr = dec.addr;
        wr_d.data = result;
        if (writes_file) begin
            wr_d.wr = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wr_q <= '0;
        end else begin
            wr_q <= wr_d;
        end
    end

    assign work_out = work_q;
    assign zero_out = zero_q;
    assign file_wr_out = wr_q;
endmodule // iom_exec
`default_nettype wire

// *** bench/iom_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module iom_checker import iom_pkg::*; (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic valid_in,
    input wire logic [13:0] opcode_in,
    input wire logic [7:0] file_data_in,
    input wire logic [6:0] file_addr_out,
    input wire iom_file_wr_type file_wr_out,
    input wire logic [7:0] work_out,
    input wire logic zero_out,
    input wire logic handled_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    wire [5:0] o = opcode_in[13:8];
    wire [7:0] k = opcode_in[7:0];
    wire h = handled_out;
    // result seen at whichever destination was written
    wire [7:0] r = file_wr_out.wr ? file_wr_out.data : work_out;
    inc_a: assert property (h && o == INCREMENT_FILE_OP |=> r == $past(file_data_in) + 8'h01) else $error("inc");
    dest_a: assert property (h && o != OR_LITERAL_INTO_WORK_OP |=> file_wr_out.wr == $past(k[7])) else $error("dest");
    orl_a: assert property (h && o == OR_LITERAL_INTO_WORK_OP |=> !file_wr_out.wr && r == ($past(work_out) | $past(k)))
        else $error("orl");
    orf_a: assert property (h && o == OR_WORK_WITH_FILE_OP |=> r == ($past(work_out) | $past(file_data_in))) else $error("orf");
    mov_a: assert property (h && o == MOVE_FILE_OP |=> r == $past(file_data_in)) else $error("mov");
    zero_a: assert property (h |=> zero_out == (r == 8'h00)) else $error("zero");
    idle_a: assert property (!h |=> !file_wr_out.wr && $stable(work_out) && $stable(zero_out)) else $error("idle");
    cover property (h && o == INCREMENT_FILE_OP && file_data_in == 8'hff);
    cover property (h && o == MOVE_FILE_OP && k[7]);
    cover property (valid_in && !h && file_addr_out == k[6:0]);
endmodule // iom_checker
bind iom_exec iom_checker chk_u (.*);
`default_nettype wire

// *** bench/tb_increment_or_move_instr_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_increment_or_move_instr_decode;
    import iom_pkg::*;
    logic clock_in = 1'b0, rst_in = 1'b1, valid_in = 1'b0, zero_out, handled_out;
    logic [13:0] opcode_in = 14'h0000;
    logic [7:0] file_data_in = 8'h00, work_out;
    logic [6:0] file_addr_out;
    iom_file_wr_type file_wr_out;
    int bad_count = 0, n_tests = 0;
    iom_exec dut_u (.*);
    initial forever #2.5 clock_in = ~clock_in;
    task give_verdict;
        if (bad_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one op, then idle a cycle; result read where the write pulse still stands
    task run(input logic [13:0] c, input logic [7:0] fd, x, input logic z, h);
        @(negedge clock_in) {valid_in, opcode_in, file_data_in} = {1'b1, c, fd};
        #1 n_tests++;
        if ({handled_out, file_addr_out} !== {h, c[6:0]}) begin
            bad_count++;
            $display("ERROR handled_addr op %h exp %h seen %h", c, {h, c[6:0]}, {handled_out, file_addr_out});
        end
        @(negedge clock_in) valid_in = 1'b0;
        n_tests++;
        if ({file_wr_out.wr, file_wr_out.wr ? file_wr_out.data : work_out, zero_out}
            !== {h && c[7] && c[13:8] != 6'h38, x, z} || (file_wr_out.wr && file_wr_out.addr !== c[6:0])) begin
            bad_count++;
            $display("ERROR result op %h exp %h seen %h", c, {x, z},
                {file_wr_out.wr, file_wr_out.addr, file_wr_out.wr ? file_wr_out.data : work_out, zero_out});
        end
    endtask
    // reset in mid-run clears working register, flag and write pulse
    task reset_check;
        @(negedge clock_in) rst_in = 1'b1;
        @(negedge clock_in) rst_in = 1'b0;
        n_tests++;
        if ({file_wr_out, work_out, zero_out} !== '0) begin
            bad_count++;
            $display("ERROR reset exp 0 seen %h", {file_wr_out, work_out, zero_out});
        end
    endtask
    initial begin
        #20000 bad_count++;
        give_verdict;
    end
    initial begin
        repeat (10) @(negedge clock_in);
        rst_in = 0;
        run(14'h0a85, 8'hff, 8'h00, 1'b1, 1'b1);
        run(14'h0a05, 8'h41, 8'h42, 1'b0, 1'b1);
        run(14'h38b5, 8'h00, 8'hf7, 1'b0, 1'b1);
        run(14'h0490, 8'h08, 8'hff, 1'b0, 1'b1);
        run(14'h0880, 8'h00, 8'h00, 1'b1, 1'b1);
        run(14'h0800, 8'h00, 8'h00, 1'b1, 1'b1);
        run(14'h0f05, 8'h12, 8'h00, 1'b1, 1'b0);
        reset_check;
        run(14'h3800, 8'h00, 8'h00, 1'b1, 1'b1);
        give_verdict;
    end
endmodule // tb_increment_or_move_instr_decode
`default_nettype wire
